// file: bench/flash_array_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Flash array stand-in: answers each request after a set delay.
// ****************************************************************
module flash_array_model (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Request side.
    input wire logic start_in,
    input wire logic [7:0] delay_in,
    // Completion side.
    output logic done_out,
    output logic overlap_out
);
    logic [7:0] count_reg;

    // A delay of at least two keeps the answer clear of the launch cycle.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            count_reg <= 8'h00;
            done_out <= 1'b0;
            overlap_out <= 1'b0;
        end else begin
            done_out <= (count_reg == 8'h01);
            overlap_out <= start_in && (count_reg != 8'h00);
            if (start_in) begin
                count_reg <= delay_in;
            end else if (count_reg != 8'h00) begin
                count_reg <= count_reg - 8'h01;
            end
        end
    end
endmodule

// file: bench/flash_ctrl_asserts.sv
`timescale 1ns/1ps

// ****************************************************************
// Port checks for the self-programming controller.
// ****************************************************************
module flash_ctrl_asserts (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Register bus.
    input wire logic [15:0] sfr_addr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_rdata_out,
    // Flash side and stall.
    input wire flash_self_prog_pkg::flash_req_t flash_req_out,
    input wire logic flash_start_out,
    input wire logic flash_done_in,
    input wire logic cpu_stall_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    // Shorthands for the request fields.
    logic [15:0] a;
    logic [1:0] s;
    logic [1:0] o;
    assign a = flash_req_out.addr;
    assign s = flash_req_out.segment;
    assign o = flash_req_out.op;

    start_pulse_a: assert property (flash_start_out |-> cpu_stall_out ##1 !flash_start_out)
        else $error("Start pulse without stall or too long.");
    stall_cause_a: assert property ($rose(cpu_stall_out) |-> flash_start_out)
        else $error("Stall rose without a launch.");
    stall_release_a: assert property (cpu_stall_out && flash_done_in |=> !cpu_stall_out)
        else $error("Stall not released after completion.");
    stall_hold_a: assert property (cpu_stall_out && !flash_done_in |=> cpu_stall_out)
        else $error("Stall dropped before completion.");
    req_hold_a: assert property (cpu_stall_out && !flash_start_out |-> $stable(flash_req_out))
        else $error("Request changed while busy.");
    word_target_a: assert property (flash_start_out && o == 2'h0 |-> !a[0] && s != 2'h3
        && !(s == 2'h0 && a[15:11] == 5'h1F) && !(s == 2'h2 && a[15:8] > 8'h07))
        else $error("Bad word write target.");
    block_target_a: assert property (flash_start_out && o == 2'h1 |-> a[13:0] == 14'h0
        && (s == 2'h1 || (s == 2'h0 && a[15:14] != 2'h3) || (s == 2'h2 && a[15:14] == 2'h0)))
        else $error("Bad block erase target.");
    sector_target_a: assert property (flash_start_out && o == 2'h2 |-> (s == 2'h2)
        ? (a[15:11] == 5'h0 && a[9:0] == 10'h0)
        : ((s == 2'h1 || (s == 2'h0 && a[15:11] != 5'h1F)) && a[10:0] == 11'h0))
        else $error("Bad sector erase target.");
    wo_read_a: assert property (sfr_rd_in && sfr_addr_in inside {16'hF0E4, 16'hF0E5}
        |=> sfr_rdata_out == 8'h00)
        else $error("Write-only register read nonzero.");
    low_bit_a: assert property (sfr_rd_in && sfr_addr_in == 16'hF0E0 |=> !sfr_rdata_out[0])
        else $error("Address bit zero read as one.");

    word_c: cover property (flash_start_out && o == 2'h0);
    block_c: cover property (flash_start_out && o == 2'h1);
    sector_c: cover property (flash_start_out && o == 2'h2);
endmodule

// file: bench/flash_self_program_ctrl_test.sv
`timescale 1ns/1ps
`include "flash_self_prog_defs.svh"

// ****************************************************************
// Register-level test of the self-programming controller.
// ****************************************************************
module flash_self_program_ctrl_test;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [15:0] sfr_addr_in = 16'h0000;
    logic sfr_wr_in = 1'b0;
    logic sfr_rd_in = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic hw_remap_pin_in = 1'b0;
    logic [7:0] delay = 8'h02;
    logic [7:0] sfr_rdata_out;
    flash_self_prog_pkg::flash_req_t flash_req_out;
    flash_self_prog_pkg::flash_req_t last_req;
    logic flash_start_out;
    logic flash_done_in;
    logic cpu_stall_out;
    logic [7:0] boot_remap_out;
    logic hw_remap_on_out;
    logic overlap;
    int num_errors = 0;
    int checks_done = 0;
    int starts = 0;
    int overlaps = 0;
    int i;
    logic [15:0] regs [10] = '{16'hF0E0, 16'hF0E1, 16'hF0E2, 16'hF0E3, 16'hF0E4, 16'hF0E5,
        16'hF0E6, 16'hF0E7, 16'hF0EC, 16'hF0E8};

    always #50 clk_sys_in = ~clk_sys_in;

    flash_self_program_ctrl u_flash_self_program_ctrl (.clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
        .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
        .flash_req_out(flash_req_out), .flash_start_out(flash_start_out),
        .flash_done_in(flash_done_in), .cpu_stall_out(cpu_stall_out),
        .hw_remap_pin_in(hw_remap_pin_in), .boot_remap_out(boot_remap_out),
        .hw_remap_on_out(hw_remap_on_out));

    flash_array_model u_flash_array_model (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .start_in(flash_start_out), .delay_in(delay), .done_out(flash_done_in),
        .overlap_out(overlap));

    // Launches are counted here, since the start pulse lasts one cycle only.
    always @(posedge clk_sys_in) begin
        if (flash_start_out === 1'b1) begin
            starts <= starts + 1;
            last_req <= flash_req_out;
        end
        if (overlap === 1'b1) begin
            overlaps <= overlaps + 1;
        end
    end

    task summarize;
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One idle cycle between writes keeps each strobe a single pulse.
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        @(negedge clk_sys_in);
        sfr_wr_in = 1'b0;
    endtask

    task rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk_sys_in);
        sfr_addr_in = a;
        sfr_rd_in = 1'b1;
        @(negedge clk_sys_in);
        sfr_rd_in = 1'b0;
        check(sfr_rdata_out, exp);
    endtask

    task arm;
        wr(`ADDR_UNLOCK_KEY, `UNLOCK_FIRST);
        wr(`ADDR_UNLOCK_KEY, `UNLOCK_SECOND);
    endtask

    // The extra cycle at the end lets the sequencer leave its done state.
    task automatic wait_idle;
        int n;
        repeat (3) @(negedge clk_sys_in);
        for (n = 0; n < 200 && cpu_stall_out !== 1'b0; n++) @(negedge clk_sys_in);
        if (n == 200) begin
            num_errors++;
            summarize;
        end
        @(negedge clk_sys_in);
    endtask

    task automatic run_case(input logic [1:0] seg, input logic [7:0] up, input logic [7:0] ctl,
        input int ok, input logic [15:0] base);
        int n0;
        logic [1:0] op;
        n0 = starts;
        op = (ctl == 8'h00) ? 2'h0 : (ctl[0] ? 2'h1 : 2'h2);
        arm;
        wr(`ADDR_SEGMENT_SELECT, {6'h00, seg});
        wr(`ADDR_PROG_ADDR_HIGH, up);
        if (ctl == 8'h00) wr(`ADDR_PROG_DATA_HIGH, 8'hA7);
        else wr(`ADDR_ERASE_CONTROL, ctl);
        wait_idle;
        check(starts - n0, ok);
        // Op, segment and address sit in bits 35 to 16 of the request.
        if (ok == 1) check(last_req[35:16], {op, seg, base});
        if (ok == 1 && ctl == 8'h00) check(last_req[15:0], 16'hA73C);
    endtask

    initial begin
        repeat (12) @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        for (i = 0; i < 10; i++) rd(regs[i], 8'h00);
        wr(`ADDR_PROG_ADDR_LOW, 8'hFF);
        rd(`ADDR_PROG_ADDR_LOW, 8'hFE);
        wr(`ADDR_SEGMENT_SELECT, 8'hFF);
        rd(`ADDR_SEGMENT_SELECT, 8'h03);
        wr(`ADDR_BOOT_REMAP, 8'h5A);
        rd(`ADDR_BOOT_REMAP, 8'h5A);
        check(boot_remap_out, 8'h5A);
        wr(`ADDR_PROG_ADDR_LOW, 8'h24);
        wr(`ADDR_PROG_DATA_LOW, 8'h3C);
        run_case(2'h0, 8'h12, 8'h00, 0, 16'h0);
        wr(`ADDR_SELF_PROG_ENABLE, 8'hFF);
        rd(`ADDR_SELF_PROG_ENABLE, 8'h01);
        // Arming survives the refused launch above.
        wr(`ADDR_PROG_DATA_HIGH, 8'hA7);
        wait_idle;
        // The boot remap is set, yet software still gives the physical address.
        check(last_req, {2'h0, 2'h0, 16'h1224, 16'hA73C});
        wr(`ADDR_PROG_DATA_HIGH, 8'hA7);
        wait_idle;
        check(starts, 1);
        wr(`ADDR_UNLOCK_KEY, 8'hFA);
        wr(`ADDR_UNLOCK_KEY, 8'h00);
        wr(`ADDR_UNLOCK_KEY, 8'hF5);
        wr(`ADDR_PROG_DATA_HIGH, 8'hA7);
        wait_idle;
        check(starts, 1);
        run_case(2'h0, 8'h7F, 8'h01, 1, 16'h4000);
        run_case(2'h0, 8'hC0, 8'h01, 0, 16'h0);
        run_case(2'h1, 8'hC3, 8'h03, 1, 16'hC000);
        run_case(2'h2, 8'h05, 8'h01, 1, 16'h0000);
        run_case(2'h3, 8'h00, 8'h01, 0, 16'h0);
        run_case(2'h0, 8'h0F, 8'h02, 1, 16'h0800);
        run_case(2'h0, 8'hF7, 8'h02, 1, 16'hF000);
        run_case(2'h0, 8'hF8, 8'h02, 0, 16'h0);
        run_case(2'h0, 8'hFD, 8'h02, 0, 16'h0);
        run_case(2'h1, 8'hFF, 8'h02, 1, 16'hF800);
        run_case(2'h2, 8'h05, 8'h02, 1, 16'h0400);
        run_case(2'h2, 8'h08, 8'h02, 0, 16'h0);
        run_case(2'h0, 8'hF8, 8'h00, 0, 16'h0);
        run_case(2'h2, 8'h07, 8'h00, 1, 16'h0724);
        // A slow array: writes during the stall must be dropped.
        delay = 8'h28;
        run_case(2'h1, 8'h08, 8'h02, 1, 16'h0800);
        arm;
        wr(`ADDR_ERASE_CONTROL, 8'h02);
        wr(`ADDR_PROG_ADDR_HIGH, 8'h33);
        check(cpu_stall_out, 1'b1);
        wait_idle;
        rd(`ADDR_PROG_ADDR_HIGH, 8'h08);
        hw_remap_pin_in = 1'b1;
        for (i = 0; i < 50 && hw_remap_on_out !== 1'b1; i++) @(negedge clk_sys_in);
        check(hw_remap_on_out, 1'b1);
        check(overlaps, 0);
        summarize;
    end

    initial begin
        #6000000;
        num_errors++;
        summarize;
    end
endmodule

bind flash_self_program_ctrl flash_ctrl_asserts u_flash_ctrl_asserts (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .sfr_addr_in(sfr_addr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_rdata_out(sfr_rdata_out), .flash_req_out(flash_req_out),
    .flash_start_out(flash_start_out), .flash_done_in(flash_done_in),
    .cpu_stall_out(cpu_stall_out));

// file: core/flash_self_program_ctrl.sv
`timescale 1ns/1ps
`include "flash_self_prog_defs.svh"

module flash_self_program_ctrl (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Special function register bus.
    input wire logic [15:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // Flash array side.
    output flash_self_prog_pkg::flash_req_t flash_req_out,
    output logic flash_start_out,
    input wire logic flash_done_in,
    // CPU stall and boot remap.
    output logic cpu_stall_out,
    input wire logic hw_remap_pin_in,
    output logic [7:0] boot_remap_out,
    output logic hw_remap_on_out
);

    // ****************************************************************
    // Register storage.
    // ****************************************************************
    logic [7:1] prog_addr_low_reg;
    logic [7:0] prog_addr_high_reg;
    logic [7:0] prog_data_low_reg;
    logic [7:0] prog_data_high_reg;
    logic [1:0] segment_select_reg;
    logic self_prog_on_reg;
    logic [7:0] boot_remap_reg;
    logic [1:0] erase_control_reg;
    flash_self_prog_pkg::key_state_t key_reg;
    flash_self_prog_pkg::seq_state_t state_reg;
    logic [2:0] pin_sync_reg;
    logic hw_remap_reg;

    // Decoded write strobes.
    logic wr_addr_low;
    logic wr_addr_high;
    logic wr_data_low;
    logic wr_data_high;
    logic wr_control;
    logic wr_key;
    logic wr_segment;
    logic wr_self;
    logic wr_remap;

    // Launch decode.
    logic block_req;
    logic sector_req;
    logic word_req;
    logic any_req;
    logic target_ok;
    logic launch;
    flash_self_prog_pkg::flash_op_t op_sel;
    logic [7:0] upper_masked;

    // Writes are refused while an operation runs; the CPU is stalled then anyway.
    assign wr_addr_low = sfr_wr_in && (sfr_addr_in == `ADDR_PROG_ADDR_LOW);
    assign wr_addr_high = sfr_wr_in && (sfr_addr_in == `ADDR_PROG_ADDR_HIGH);
    assign wr_data_low = sfr_wr_in && (sfr_addr_in == `ADDR_PROG_DATA_LOW);
    assign wr_data_high = sfr_wr_in && (sfr_addr_in == `ADDR_PROG_DATA_HIGH);
    assign wr_control = sfr_wr_in && (sfr_addr_in == `ADDR_ERASE_CONTROL);
    assign wr_key = sfr_wr_in && (sfr_addr_in == `ADDR_UNLOCK_KEY);
    assign wr_segment = sfr_wr_in && (sfr_addr_in == `ADDR_SEGMENT_SELECT);
    assign wr_self = sfr_wr_in && (sfr_addr_in == `ADDR_SELF_PROG_ENABLE);
    assign wr_remap = sfr_wr_in && (sfr_addr_in == `ADDR_BOOT_REMAP);

    // ****************************************************************
    // Start request decode.
    // ****************************************************************

    // Block erase wins when both control bits are written high.
    assign block_req = wr_control && sfr_wdata_in[`BIT_BLOCK_ERASE_START];
    assign sector_req = wr_control && !sfr_wdata_in[`BIT_BLOCK_ERASE_START]
        && sfr_wdata_in[`BIT_SECTOR_ERASE_START];
    assign word_req = wr_data_high;
    assign any_req = block_req || sector_req || word_req;

    // Operation kind for this request.
    always_comb begin
        if (block_req) begin
            op_sel = flash_self_prog_pkg::OP_BLOCK_ERASE;
        end else if (sector_req) begin
            op_sel = flash_self_prog_pkg::OP_SECTOR_ERASE;
        end else begin
            op_sel = flash_self_prog_pkg::OP_WORD_WRITE;
        end
    end

    // Target check against segment, range and the protected test area.
    always_comb begin
        target_ok = 1'b0;
        unique case (op_sel)
            flash_self_prog_pkg::OP_BLOCK_ERASE: begin
                // Segment 0 offers three blocks, segment 1 four, segment 2 its whole 2 KB.
                unique case (segment_select_reg)
                    `SEG_CODE_0: target_ok = prog_addr_high_reg[7:6]
                        <= `SEGMENT_CODE_LO_BLOCK_LAST_QUARTER;
                    `SEG_CODE_1: target_ok = 1'b1;
                    `SEG_CODE_2: target_ok = prog_addr_high_reg[7:6] == 2'h0;
                    default: target_ok = 1'b0;
                endcase
            end
            flash_self_prog_pkg::OP_SECTOR_ERASE: begin
                unique case (segment_select_reg)
                    `SEG_CODE_0: target_ok = prog_addr_high_reg
                        < `TEST_AREA_UPPER_FIRST;
                    `SEG_CODE_1: target_ok = 1'b1;
                    `SEG_CODE_2: target_ok = prog_addr_high_reg
                        <= `SEG2_UPPER_LAST;
                    default: target_ok = 1'b0;
                endcase
            end
            default: begin
                unique case (segment_select_reg)
                    `SEG_CODE_0: target_ok = prog_addr_high_reg
                        < `TEST_AREA_UPPER_FIRST;
                    `SEG_CODE_1: target_ok = 1'b1;
                    `SEG_CODE_2: target_ok = prog_addr_high_reg <= `SEG2_UPPER_LAST;
                    default: target_ok = 1'b0;
                endcase
            end
        endcase
    end

    // A bad start is simply dropped; the array never sees it.
    assign launch = any_req && (state_reg == flash_self_prog_pkg::ST_IDLE)
        && (key_reg == flash_self_prog_pkg::KEY_ARMED)
        && self_prog_on_reg && target_ok;

    // Erase targets are aligned to their unit by masking the low upper bits.
    always_comb begin
        unique case (op_sel)
            flash_self_prog_pkg::OP_BLOCK_ERASE:
                upper_masked = prog_addr_high_reg & `BLOCK_MASK_16K;
            flash_self_prog_pkg::OP_SECTOR_ERASE:
                upper_masked = (segment_select_reg == `SEG_CODE_2)
                    ? (prog_addr_high_reg & `SECTOR_MASK_1K)
                    : (prog_addr_high_reg & `SECTOR_MASK_2K);
            default:
                upper_masked = prog_addr_high_reg;
        endcase
    end

    // ****************************************************************
    // Software registers.
    // ****************************************************************

    // Address registers; bit 0 of the low byte is not stored at all.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            prog_addr_low_reg <= 7'h00;
            prog_addr_high_reg <= `REG_RESET_VALUE;
        end else if (state_reg == flash_self_prog_pkg::ST_IDLE) begin
            if (wr_addr_low) begin
                prog_addr_low_reg <= sfr_wdata_in[7:1];
            end
            if (wr_addr_high) begin
                prog_addr_high_reg <= sfr_wdata_in;
            end
        end
    end

    // Data registers; the high byte write doubles as the word launch.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            prog_data_low_reg <= `REG_RESET_VALUE;
            prog_data_high_reg <= `REG_RESET_VALUE;
        end else if (state_reg == flash_self_prog_pkg::ST_IDLE) begin
            if (wr_data_low) begin
                prog_data_low_reg <= sfr_wdata_in;
            end
            if (wr_data_high) begin
                prog_data_high_reg <= sfr_wdata_in;
            end
        end
    end

    // Segment, enable and remap configuration.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            segment_select_reg <= 2'h0;
            self_prog_on_reg <= 1'b0;
            boot_remap_reg <= `REG_RESET_VALUE;
        end else if (state_reg == flash_self_prog_pkg::ST_IDLE) begin
            if (wr_segment) begin
                segment_select_reg <= sfr_wdata_in[1:0];
            end
            if (wr_self) begin
                self_prog_on_reg <= sfr_wdata_in[`BIT_SELF_PROG_ON];
            end
            if (wr_remap) begin
                boot_remap_reg <= sfr_wdata_in;
            end
        end
    end

    // Unlock key: FA then F5 arms, anything but FA or F5 after FA drops back, a launch consumes.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            key_reg <= flash_self_prog_pkg::KEY_LOCKED;
        end else if (launch) begin
            key_reg <= flash_self_prog_pkg::KEY_LOCKED;
        end else if (wr_key && state_reg == flash_self_prog_pkg::ST_IDLE) begin
            if (sfr_wdata_in == `UNLOCK_FIRST) begin
                key_reg <= flash_self_prog_pkg::KEY_HALF;
            end else if (sfr_wdata_in == `UNLOCK_SECOND
                && key_reg == flash_self_prog_pkg::KEY_HALF) begin
                key_reg <= flash_self_prog_pkg::KEY_ARMED;
            end else if (key_reg == flash_self_prog_pkg::KEY_HALF) begin
                key_reg <= flash_self_prog_pkg::KEY_LOCKED;
            end
        end
    end

    // ****************************************************************
    // Operation sequencer.
    // ****************************************************************

    // Busy from launch until the array reports done; the stall drops on the same edge that enters the done state.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            state_reg <= flash_self_prog_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                flash_self_prog_pkg::ST_IDLE:
                    if (launch) begin
                        state_reg <= flash_self_prog_pkg::ST_RUN;
                    end
                flash_self_prog_pkg::ST_RUN:
                    if (flash_done_in) begin
                        state_reg <= flash_self_prog_pkg::ST_DONE;
                    end
                flash_self_prog_pkg::ST_DONE:
                    state_reg <= flash_self_prog_pkg::ST_IDLE;
                default:
                    state_reg <= flash_self_prog_pkg::ST_IDLE;
            endcase
        end
    end

    // Erase start bits are held while erasing and clear themselves at completion.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            erase_control_reg <= 2'h0;
        end else if (launch && block_req) begin
            erase_control_reg <= 2'h1;
        end else if (launch && sector_req) begin
            erase_control_reg <= 2'h2;
        end else if (state_reg == flash_self_prog_pkg::ST_RUN && flash_done_in) begin
            erase_control_reg <= 2'h0;
        end
    end

    // Request to the array, captured once at launch and held until done.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            flash_req_out <= '0;
            flash_start_out <= 1'b0;
            cpu_stall_out <= 1'b0;
        end else begin
            flash_start_out <= launch;
            if (launch) begin
                flash_req_out.op <= op_sel;
                flash_req_out.segment <= segment_select_reg;
                flash_req_out.addr <= (op_sel == flash_self_prog_pkg::OP_WORD_WRITE)
                    ? {prog_addr_high_reg, prog_addr_low_reg, 1'b0}
                    : {upper_masked, 8'h00};
                flash_req_out.data <= {(word_req ? sfr_wdata_in : prog_data_high_reg),
                    prog_data_low_reg};
                cpu_stall_out <= 1'b1;
            end else if (state_reg == flash_self_prog_pkg::ST_RUN && flash_done_in) begin
                cpu_stall_out <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Boot remap pin and outputs.
    // ****************************************************************

    // The pin is asynchronous, so three stages; a change counts once stages two and three agree.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            pin_sync_reg <= 3'h0;
            hw_remap_reg <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], hw_remap_pin_in};
            if (pin_sync_reg[1] == pin_sync_reg[2]) begin
                hw_remap_reg <= pin_sync_reg[2];
            end
        end
    end

    // Remap outputs follow the registers one cycle later.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            boot_remap_out <= `REG_RESET_VALUE;
            hw_remap_on_out <= 1'b0;
        end else begin
            boot_remap_out <= boot_remap_reg;
            hw_remap_on_out <= hw_remap_reg;
        end
    end

    // Read data; write-only registers and unmapped addresses read as zero.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            sfr_rdata_out <= `REG_RESET_VALUE;
        end else if (sfr_rd_in) begin
            unique case (sfr_addr_in)
                `ADDR_PROG_ADDR_LOW: sfr_rdata_out <= {prog_addr_low_reg, 1'b0};
                `ADDR_PROG_ADDR_HIGH: sfr_rdata_out <= prog_addr_high_reg;
                `ADDR_PROG_DATA_LOW: sfr_rdata_out <= prog_data_low_reg;
                `ADDR_PROG_DATA_HIGH: sfr_rdata_out <= prog_data_high_reg;
                `ADDR_SEGMENT_SELECT: sfr_rdata_out <= {6'h00, segment_select_reg};
                `ADDR_SELF_PROG_ENABLE: sfr_rdata_out <= {7'h00, self_prog_on_reg};
                `ADDR_BOOT_REMAP: sfr_rdata_out <= boot_remap_reg;
                default: sfr_rdata_out <= `REG_RESET_VALUE;
            endcase
        end
    end

endmodule

// file: pkg/flash_self_prog_defs.svh
`ifndef FLASH_SELF_PROG_DEFS_SVH
`define FLASH_SELF_PROG_DEFS_SVH

// ****************************************************************
// Register offsets on the special function register bus.
// ****************************************************************
`define ADDR_PROG_ADDR_LOW 16'hF0E0
`define ADDR_PROG_ADDR_HIGH 16'hF0E1
`define ADDR_PROG_DATA_LOW 16'hF0E2
`define ADDR_PROG_DATA_HIGH 16'hF0E3
`define ADDR_ERASE_CONTROL 16'hF0E4
`define ADDR_UNLOCK_KEY 16'hF0E5
`define ADDR_SEGMENT_SELECT 16'hF0E6
`define ADDR_SELF_PROG_ENABLE 16'hF0E7
`define ADDR_BOOT_REMAP 16'hF0EC

// ****************************************************************
// Reset values and field positions.
// ****************************************************************
`define REG_RESET_VALUE 8'h00
`define BIT_BLOCK_ERASE_START 0
`define BIT_SECTOR_ERASE_START 1
`define BIT_SELF_PROG_ON 0
`define SEG_FIELD_MASK 8'h03

// ****************************************************************
// Unlock key values.
// ****************************************************************
`define UNLOCK_FIRST 8'hFA
`define UNLOCK_SECOND 8'hF5

// ****************************************************************
// Segment codes and address limits, as upper address bytes.
// ****************************************************************
`define SEG_CODE_0 2'h0
`define SEG_CODE_1 2'h1
`define SEG_CODE_2 2'h2
`define SEGMENT_CODE_LO_BLOCK_LAST_QUARTER 2'h2
`define TEST_AREA_UPPER_FIRST 8'hF8
`define SEG2_UPPER_LAST 8'h07
`define SECTOR_MASK_2K 8'hF8
`define SECTOR_MASK_1K 8'hFC
`define BLOCK_MASK_16K 8'hC0

`endif

// file: pkg/flash_self_prog_pkg.sv
package flash_self_prog_pkg;

    // Operation kinds handed to the flash array.
    typedef enum logic [1:0] {
        OP_WORD_WRITE = 2'h0,
        OP_BLOCK_ERASE = 2'h1,
        OP_SECTOR_ERASE = 2'h2
    } flash_op_t;

    // Sequencer states, Gray coded along idle, run, done.
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN = 2'h1,
        ST_DONE = 2'h3
    } seq_state_t;

    // Unlock key progress.
    typedef enum logic [1:0] {
        KEY_LOCKED = 2'h0,
        KEY_HALF = 2'h1,
        KEY_ARMED = 2'h3
    } key_state_t;

    // One request towards the flash array.
    typedef struct packed {
        flash_op_t op;
        logic [1:0] segment;
        logic [15:0] addr;
        logic [15:0] data;
    } flash_req_t;

endpackage
